// ### chan_status_pkg.sv
// Constants for the channel-status register bank
//
// Operation
// - Category code read-only eight bits, zero general
// - Source number in low nibble, resets zero
// - Bits 5:4 hold sub-frame one channel
// - Bits 7:6 hold sub-frame two channel
// - Indicated rate code four bits, resets 0001
// - Clock accuracy bits 5:4, resets 11
// - Bit 0 max length, bits 3:1 length
// - Original rate code bits 7:4, resets zero
// - Consumer/professional select bit, resets consumer
package chan_status_pkg;
  // ---------------------------------------------
  // Register indices; byte address is index times four
  // ---------------------------------------------
  localparam logic [7:0] IDX_RX_CATEGORY = 8'h0e;
  localparam logic [7:0] IDX_RX_SRC_CHAN = 8'h0f;
  localparam logic [7:0] IDX_RX_RATE_ACC = 8'h10;
  localparam logic [7:0] IDX_RX_WORD_LEN = 8'h11;
  localparam logic [7:0] IDX_TX_CFG_FIRST = 8'h12;
  // ---------------------------------------------
  // Field positions
  // ---------------------------------------------
  localparam int SRC_LSB = 0;
  localparam int CH1_LSB = 4;
  localparam int CH2_LSB = 6;
  localparam int RATE_LSB = 0;
  localparam int ACC_LSB = 4;
  localparam int MAX_SAMPLE_LENGTH_FLAG_BIT = 0;
  localparam int WLEN_LSB = 1;
  localparam int ORIG_LSB = 4;
  localparam int CONPRO_BIT = 0;
  // ---------------------------------------------
  // Reset values
  // ---------------------------------------------
  localparam logic [7:0] RST_CATEGORY = 8'h00;
  localparam logic [3:0] RST_SOURCE = 4'h0;
  localparam logic [1:0] RST_CHAN = 2'h0;
  localparam logic [3:0] RST_RATE = 4'h1;
  localparam logic [1:0] RST_ACCURACY = 2'h3;
  localparam logic RST_MAX_SAMPLE_LENGTH_FLAG = 1'b1;
  localparam logic [2:0] RST_WLEN = 3'h0;
  localparam logic [3:0] RST_ORIG = 4'h0;
  localparam logic RST_CONPRO = 1'b0;
endpackage

// ### channel_status_register_bank.sv
// AHB-Lite register bank for received channel-status fields
`timescale 1ns/1ps
module channel_status_register_bank
  import chan_status_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic blockValid,
  input wire logic [39:0] blockBits,
  output logic consumerProfessionalSelect,
  output logic [4:0] sampleLengthBits
);

  // ---------------------------------------------
  // Captured fields
  // ---------------------------------------------
  logic [7:0] categoryField_q;
  logic [3:0] sourceIndex_q;
  logic [1:0] subframeOneChannel_q;
  logic [1:0] subframeTwoChannel_q;
  logic [3:0] indicatedRateCode_q;
  logic [1:0] clockAccuracyLevel_q;
  logic maxSampleLengthFlag_q;
  logic [2:0] receivedSampleLengthCode_q;
  logic [3:0] originalRateCode_q;
  logic conPro_q;
  logic [7:0] wrIdx_q;
  logic wrPend_q;

  // Decode of the length code against the max flag; zero means unknown
  function automatic logic [4:0] lenBits(input logic maxFlag, input logic [2:0] code);
    logic [4:0] base;
    base = 5'd0;
    case (code)
      3'h1: base = 5'd20;
      3'h2: base = 5'd22;
      3'h4: base = 5'd23;
      3'h5: base = 5'd24;
      3'h6: base = 5'd21;
      default: base = 5'd0;
    endcase
    if (base != 5'd0 && !maxFlag) begin
      base = base - 5'd4;
    end
    return base;
  endfunction

  // Byte address from a register index
  function automatic logic [31:0] byteAddr(input logic [7:0] idx);
    return {22'h0, idx, 2'h0};
  endfunction

  // ---------------------------------------------
  // Capture of the received block
  // ---------------------------------------------
  // Whole block loaded at once so a read never mixes two blocks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      categoryField_q <= RST_CATEGORY;
      sourceIndex_q <= RST_SOURCE;
      subframeOneChannel_q <= RST_CHAN;
      subframeTwoChannel_q <= RST_CHAN;
      indicatedRateCode_q <= RST_RATE;
      clockAccuracyLevel_q <= RST_ACCURACY;
      maxSampleLengthFlag_q <= RST_MAX_SAMPLE_LENGTH_FLAG;
      receivedSampleLengthCode_q <= RST_WLEN;
      originalRateCode_q <= RST_ORIG;
    end else if (clkEn && blockValid) begin
      categoryField_q <= blockBits[15:8];
      sourceIndex_q <= blockBits[19:16];
      subframeOneChannel_q <= blockBits[21:20];
      subframeTwoChannel_q <= blockBits[23:22];
      indicatedRateCode_q <= blockBits[27:24];
      clockAccuracyLevel_q <= blockBits[29:28];
      maxSampleLengthFlag_q <= blockBits[32];
      receivedSampleLengthCode_q <= blockBits[35:33];
      originalRateCode_q <= blockBits[39:36];
    end
  end

  // Decoded sample length for the audio path
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sampleLengthBits <= 5'd0;
    end else if (clkEn) begin
      sampleLengthBits <= lenBits(maxSampleLengthFlag_q, receivedSampleLengthCode_q);
    end
  end

  // ---------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------
  logic phaseOk;
  assign phaseOk = hsel && hready && htrans[1];

  // Address phase capture of writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 8'h00;
    end else if (clkEn) begin
      wrPend_q <= phaseOk && hwrite && haddr[31:10] == 22'h0;
      wrIdx_q <= haddr[9:2];
    end
  end

  // Only the select bit is writable; received fields ignore writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      conPro_q <= RST_CONPRO;
    end else if (clkEn && wrPend_q && wrIdx_q == IDX_TX_CFG_FIRST) begin
      conPro_q <= hwdata[CONPRO_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      consumerProfessionalSelect <= RST_CONPRO;
    end else if (clkEn) begin
      consumerProfessionalSelect <= conPro_q;
    end
  end

  // Read data registered in the address phase; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0;
    end else if (clkEn && phaseOk && !hwrite) begin
      case ({haddr[31:2], 2'h0})
        byteAddr(IDX_RX_CATEGORY): hrdata <= {24'h0, categoryField_q};
        byteAddr(IDX_RX_SRC_CHAN): hrdata <= {24'h0, subframeTwoChannel_q,
          subframeOneChannel_q, sourceIndex_q};
        byteAddr(IDX_RX_RATE_ACC): hrdata <= {26'h0, clockAccuracyLevel_q,
          indicatedRateCode_q};
        byteAddr(IDX_RX_WORD_LEN): hrdata <= {24'h0, originalRateCode_q,
          receivedSampleLengthCode_q, maxSampleLengthFlag_q};
        byteAddr(IDX_TX_CFG_FIRST): hrdata <= {31'h0, conPro_q};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clkEn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  // Capture of each field from an accepted block; channel one also held without a block
  a_capture_category: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && blockValid |=> categoryField_q == $past(blockBits[15:8]))
    else $error("category not captured");
  a_capture_source: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && blockValid |=> sourceIndex_q == $past(blockBits[19:16]))
    else $error("source not captured");
  a_chan_one_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !blockValid |=> $stable(subframeOneChannel_q))
    else $error("channel one changed");
  a_chan_two_cap: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && blockValid |=> subframeTwoChannel_q == $past(blockBits[23:22]))
    else $error("channel two not captured");
  a_capture_chan_one: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && blockValid |=> subframeOneChannel_q == $past(blockBits[21:20]))
    else $error("channel one not captured");
  a_capture_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && blockValid |=> indicatedRateCode_q == $past(blockBits[27:24]))
    else $error("rate not captured");
  a_capture_accuracy: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && blockValid |=> clockAccuracyLevel_q == $past(blockBits[29:28]))
    else $error("accuracy not captured");
  a_capture_max_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && blockValid |=> maxSampleLengthFlag_q == $past(blockBits[32]))
    else $error("max flag not captured");
  a_capture_len_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && blockValid |=> receivedSampleLengthCode_q == $past(blockBits[35:33]))
    else $error("length code not captured");
  a_orig_cap: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && blockValid |=> originalRateCode_q == $past(blockBits[39:36]))
    else $error("original rate not captured");

  // Frozen clock enable keeps every field, so a stalled core sees no tearing
  a_freeze_category: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(categoryField_q))
    else $error("category moved while frozen");
  a_freeze_source: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(sourceIndex_q))
    else $error("source moved while frozen");
  a_freeze_chan_one: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(subframeOneChannel_q))
    else $error("channel one moved while frozen");
  a_freeze_chan_two: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(subframeTwoChannel_q))
    else $error("channel two moved while frozen");
  a_freeze_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(indicatedRateCode_q))
    else $error("rate moved while frozen");
  a_freeze_accuracy: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(clockAccuracyLevel_q))
    else $error("accuracy moved while frozen");
  a_freeze_length: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(maxSampleLengthFlag_q) && $stable(receivedSampleLengthCode_q))
    else $error("length moved while frozen");
  a_freeze_orig: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(originalRateCode_q))
    else $error("original rate moved while frozen");
  a_freeze_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(conPro_q) && $stable(consumerProfessionalSelect))
    else $error("select moved while frozen");
  a_freeze_len_out: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clkEn |=> $stable(sampleLengthBits))
    else $error("length output moved while frozen");

  // Without a new block the bank keeps the last one
  a_hold_category: assert property (@(posedge core_clk) disable iff (sys_rst)
    !blockValid |=> $stable(categoryField_q))
    else $error("category changed without block");
  a_hold_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !blockValid |=> $stable(indicatedRateCode_q) && $stable(clockAccuracyLevel_q))
    else $error("rate changed without block");
  a_hold_orig: assert property (@(posedge core_clk) disable iff (sys_rst)
    !blockValid |=> $stable(originalRateCode_q))
    else $error("original rate changed without block");

  // Reset values
  a_rate_reset: assert property (@(posedge core_clk)
    sys_rst |=> indicatedRateCode_q == RST_RATE)
    else $error("rate reset wrong");
  a_accuracy_reset: assert property (@(posedge core_clk)
    sys_rst |=> clockAccuracyLevel_q == RST_ACCURACY && maxSampleLengthFlag_q)
    else $error("accuracy reset wrong");
  a_reset_category: assert property (@(posedge core_clk)
    sys_rst |=> categoryField_q == RST_CATEGORY)
    else $error("category reset wrong");
  a_reset_source: assert property (@(posedge core_clk)
    sys_rst |=> sourceIndex_q == RST_SOURCE)
    else $error("source reset wrong");
  a_reset_chan: assert property (@(posedge core_clk)
    sys_rst |=> subframeOneChannel_q == RST_CHAN)
    else $error("channel one reset wrong");
  a_reset_chan_two: assert property (@(posedge core_clk)
    sys_rst |=> subframeTwoChannel_q == RST_CHAN)
    else $error("channel two reset wrong");
  a_reset_length: assert property (@(posedge core_clk)
    sys_rst |=> receivedSampleLengthCode_q == RST_WLEN && maxSampleLengthFlag_q == RST_MAX_SAMPLE_LENGTH_FLAG)
    else $error("length reset wrong");
  a_reset_orig: assert property (@(posedge core_clk)
    sys_rst |=> originalRateCode_q == RST_ORIG)
    else $error("original rate reset wrong");
  a_reset_select: assert property (@(posedge core_clk)
    sys_rst |=> conPro_q == RST_CONPRO && consumerProfessionalSelect == RST_CONPRO)
    else $error("select reset wrong");

  // Length table, both maxima, written out so a broken decode shows
  a_len_decode: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h5
    |=> sampleLengthBits == 5'd24)
    else $error("length decode wrong");
  a_len_five_short: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && !maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h5 |=> sampleLengthBits == 5'd20)
    else $error("length 101 short wrong");
  a_len_one_long: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h1 |=> sampleLengthBits == 5'd20)
    else $error("length 001 long wrong");
  a_len_one_short: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && !maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h1 |=> sampleLengthBits == 5'd16)
    else $error("length 001 short wrong");
  a_len_two_long: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h2 |=> sampleLengthBits == 5'd22)
    else $error("length 010 long wrong");
  a_len_two_short: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && !maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h2 |=> sampleLengthBits == 5'd18)
    else $error("length 010 short wrong");
  a_len_four_long: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h4 |=> sampleLengthBits == 5'd23)
    else $error("length 100 long wrong");
  a_len_four_short: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && !maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h4 |=> sampleLengthBits == 5'd19)
    else $error("length 100 short wrong");
  a_len_six_long: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h6 |=> sampleLengthBits == 5'd21)
    else $error("length 110 long wrong");
  a_len_six_short: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && !maxSampleLengthFlag_q && receivedSampleLengthCode_q == 3'h6 |=> sampleLengthBits == 5'd17)
    else $error("length 110 short wrong");
  a_len_unindicated: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && receivedSampleLengthCode_q == 3'h0 |=> sampleLengthBits == 5'd0)
    else $error("unindicated length not zero");
  a_len_reserved: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && receivedSampleLengthCode_q[1:0] == 2'h3 |=> sampleLengthBits == 5'd0)
    else $error("reserved length not zero");

  // Bus reads return the fields in the low byte, zero above
  a_read_category: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && phaseOk && !hwrite && haddr == byteAddr(IDX_RX_CATEGORY)
    |=> hrdata == {24'h0, $past(categoryField_q)})
    else $error("category read wrong");
  a_read_src_chan: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && phaseOk && !hwrite && haddr == byteAddr(IDX_RX_SRC_CHAN)
    |=> hrdata[3:0] == $past(sourceIndex_q) && hrdata[31:8] == 24'h0)
    else $error("source read wrong");
  a_read_rate_acc: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && phaseOk && !hwrite && haddr == byteAddr(IDX_RX_RATE_ACC)
    |=> hrdata == {26'h0, $past(clockAccuracyLevel_q), $past(indicatedRateCode_q)})
    else $error("rate read wrong");
  a_read_word_len: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && phaseOk && !hwrite && haddr == byteAddr(IDX_RX_WORD_LEN)
    |=> hrdata[7:4] == $past(originalRateCode_q) && hrdata[31:8] == 24'h0)
    else $error("word length read wrong");
  a_read_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && phaseOk && !hwrite && haddr == byteAddr(IDX_TX_CFG_FIRST)
    |=> hrdata == {31'h0, $past(conPro_q)})
    else $error("select read wrong");
  a_read_unmapped: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && phaseOk && !hwrite && haddr[31:10] != 22'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_hrdata_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(clkEn && phaseOk && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  a_ready_high: assert property (@(posedge core_clk) disable iff (sys_rst)
    hreadyout == 1'b1)
    else $error("wait state inserted");
  a_resp_okay: assert property (@(posedge core_clk) disable iff (sys_rst)
    hresp == 1'b0)
    else $error("error response given");

  // Writes reach only the select bit
  a_ro_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && wrPend_q && wrIdx_q != IDX_TX_CFG_FIRST |=> $stable(conPro_q))
    else $error("select changed by other write");
  a_select_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && wrPend_q && wrIdx_q == IDX_TX_CFG_FIRST |=> conPro_q == $past(hwdata[CONPRO_BIT]))
    else $error("select register not written");
  a_conpro_out: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && wrPend_q && wrIdx_q == IDX_TX_CFG_FIRST && $past(clkEn)
    ##1 clkEn |=> consumerProfessionalSelect == $past(hwdata[0], 2))
    else $error("select bit not written");

endmodule

// ### tb_channel_status_register_bank.sv
// Self-checking testbench for the channel-status register bank
`timescale 1ns/1ps
module tb_channel_status_register_bank import chan_status_pkg::*; ;
  // ---------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic hsel = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic blockValid = 1'b0;
  logic [39:0] blockBits = 40'h0;
  logic consumerProfessionalSelect;
  logic [4:0] sampleLengthBits;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h3627;
  logic [31:0] rd;
  logic [39:0] blk;

  // Single slave, so its ready output is the bus ready
  channel_status_register_bank DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hsel(hsel),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .blockValid(blockValid), .blockBits(blockBits),
    .consumerProfessionalSelect(consumerProfessionalSelect),
    .sampleLengthBits(sampleLengthBits));

  always #50 core_clk = ~core_clk;

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] addrOf(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  // Expected decoded length; reserved codes give zero
  function automatic logic [4:0] expLen(input logic [7:0] w);
    logic [4:0] base;
    case (w[3:1])
      3'b001: base = 5'd20;
      3'b010: base = 5'd22;
      3'b100: base = 5'd23;
      3'b101: base = 5'd24;
      3'b110: base = 5'd21;
      default: return 5'd0;
    endcase
    return w[0] ? base : base - 5'd4;
  endfunction

  // One single transfer; waits on ready in both phases, never on a fixed count
  task automatic busXfer(input logic [31:0] addr, input logic wr, input logic [31:0] wdata);
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wdata;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic readCheck(input logic [31:0] addr, input logic [31:0] mask,
                           input logic [31:0] exp);
    busXfer(addr, 1'b0, 32'h0);
    check(rd & mask, exp);
  endtask

  // Stale bits are inverted afterwards so a late recapture shows up
  task automatic sendBlock(input logic [39:0] b, input logic en);
    blockBits <= b;
    blockValid <= 1'b1;
    clkEn <= en;
    @(posedge core_clk);
    blockValid <= 1'b0;
    clkEn <= 1'b1;
    blockBits <= ~b;
    repeat (2) @(posedge core_clk);
  endtask

  // Unused upper bits of every received-field register must read zero
  task automatic checkBlock(input logic [39:0] b);
    readCheck(addrOf(IDX_RX_CATEGORY), 32'hffffffff, {24'h0, b[15:8]});
    readCheck(addrOf(IDX_RX_SRC_CHAN), 32'hffffffff, {24'h0, b[23:16]});
    readCheck(addrOf(IDX_RX_RATE_ACC), 32'hffffffff, {26'h0, b[29:24]});
    readCheck(addrOf(IDX_RX_WORD_LEN), 32'hffffffff, {24'h0, b[39:32]});
    check({27'h0, sampleLengthBits}, {27'h0, expLen(b[39:32])});
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    checkBlock(40'h0131000000);
    readCheck(addrOf(IDX_TX_CFG_FIRST), 32'hffffffff, 32'h0);
    check({31'h0, consumerProfessionalSelect}, 32'h0);
    readCheck(32'h0000004c, 32'hffffffff, 32'h0);
    $display("test reset_values done");
    // First sixteen blocks sweep every length code with both maxima
    for (int i = 0; i < 40; i++) begin
      blk[31:0] = $random(seed);
      blk[39:32] = 8'($random(seed));
      if (i < 16) blk[35:32] = 4'(i);
      sendBlock(blk, 1'b1);
      checkBlock(blk);
    end
    $display("test block_capture done");
    // A block offered while frozen must leave the bank untouched
    sendBlock(~blk, 1'b0);
    checkBlock(blk);
    busXfer(addrOf(IDX_RX_CATEGORY), 1'b1, 32'hffffffff);
    busXfer(addrOf(IDX_RX_WORD_LEN), 1'b1, 32'h0);
    checkBlock(blk);
    $display("test read_only done");
    // Select bit set then cleared; upper data bits must not stick
    for (int v = 1; v >= 0; v--) begin
      busXfer(addrOf(IDX_TX_CFG_FIRST), 1'b1, {31'h7fffffff, 1'(v)});
      @(posedge core_clk);
      #1;
      check({31'h0, consumerProfessionalSelect}, {31'h0, 1'(v)});
      readCheck(addrOf(IDX_TX_CFG_FIRST), 32'hffffffff, {31'h0, 1'(v)});
    end
    $display("test tx_select done");
    finish_test;
  end

  // Run needs well under 100 us; a hang is cut off here
  initial begin
    #1000000;
    n_fail++;
    finish_test;
  end
endmodule
